// ---- pmcsr_pkg.sv ----
// Constants and carrier types of the power control and status register bank
package pmcsr_pkg;

  // ----------------------------------------------------------------
  // Register offsets and bus widths
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] OFS_CTRL        = 12'h000;
  localparam logic [11:0] OFS_CSTS        = 12'h004;

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int          CTRL_LPSEL_POS  = 0;
  localparam int          CTRL_SBSEL_POS  = 1;
  localparam int          CTRL_WCLR_POS   = 2;
  localparam int          CTRL_SCLR_POS   = 3;
  localparam int          CTRL_DETEN_POS  = 4;
  localparam int          CTRL_THR_LSB    = 5;
  localparam int          CTRL_THR_MSB    = 7;
  localparam int          CTRL_BKWEN_POS  = 8;
  localparam int          CTRL_FLPD_POS   = 9;
  localparam int          CTRL_SCALE_POS  = 14;

  // ----------------------------------------------------------------
  // Status register field positions
  // ----------------------------------------------------------------
  localparam int          CSTS_WAKE_POS   = 0;
  localparam int          CSTS_SBY_POS    = 1;
  localparam int          CSTS_BELOW_POS  = 2;
  localparam int          CSTS_BKRDY_POS  = 3;
  localparam int          CSTS_WPEN_POS   = 8;
  localparam int          CSTS_BKEN_POS   = 9;
  localparam int          CSTS_SCRDY_POS  = 14;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST_VAL    = 32'h0000_4000;
  localparam logic [31:0] CSTS_RST_VAL    = 32'h0000_0000;
  localparam int          WCLR_DLY_CYC    = 2;
  localparam int          SYNC_STAGES     = 2;
  localparam int          NUM_SYNC        = 4;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       scaling_sel;
    logic       flash_powerdown_in_stop;
    logic       backup_domain_write_enable;
    logic [2:0] detector_threshold_select;
    logic       supply_detector_enable;
    logic       deepsleep_standby_sel;
    logic       stop_regulator_lowpower_sel;
  } pmcsr_ctrl_t;

  typedef struct packed {
    logic scaling_ready_flag;
    logic backup_regulator_enable;
    logic wake_pin_function_enable;
    logic backup_regulator_ready_flag;
    logic supply_below_threshold_flag;
    logic standby_entered_flag;
    logic wake_event_flag;
  } pmcsr_csts_t;

  typedef enum logic [1:0] {
    PMCSR_IDLE = 2'b00,
    PMCSR_WAIT = 2'b01,
    PMCSR_ACC  = 2'b11
  } pmcsr_bus_st_t;

endpackage

// ---- pmcsr_regs.sv ----
// Power control and status register bank with its peripheral bus slave
//
// Overview of operation
// - Control bit 0 picks normal or low-power regulator in stop mode.
// - Control bit 1 picks stop (0) or standby (1) on deep sleep.
// - Writing 1 to control bit 2 clears wake flag two cycles later.
// - Writing 1 to control bit 3 clears the standby flag.
// - Control bit 4 enables the supply voltage detector.
// - Control bits 7:5 choose one of eight rising detector thresholds.
// - Control bit 8 permits backup domain writes; blocked after reset.
// - Control bit 9 powers the flash down on stop entry.
// - Control bit 14 picks scaling level 1 (1) or level 2 (0).
// - Control resets to 0x00004000, also on wake from standby.
// - Status resets to zero on power-on, survives standby wake except bit 8.
// - Status reads take one extra bus wait cycle.
// - Wake flag set by wake pin or any clock-calendar wake event.
// - Enabled wake pin raises an event while it is high.
// - Standby flag set on standby entry, cleared by power-on or strobe.
// - Status bit 9 enables backup regulator, bit 3 shows it ready.
// - Status bit 8 lets wake pin wake from standby; system reset clears.
// - Status bit 14 read-only, shows scaling level settled.
// - Standby entered on wait only with deep sleep, bit 1 set, wake flag 0.
`timescale 1ns/1ns
`default_nettype none
module pmcsr_regs (
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        sys_rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        wake_pin_i,
  input  wire logic        rtc_alarm_i,
  input  wire logic        rtc_tamper_i,
  input  wire logic        rtc_timestamp_i,
  input  wire logic        rtc_wakeup_i,
  input  wire logic        detector_below_i,
  input  wire logic        backup_regulator_ready_i,
  input  wire logic        scaling_ready_i,
  input  wire logic        deepsleep_i,
  input  wire logic        wait_instr_i,
  output pmcsr_pkg::pmcsr_ctrl_t ctrl_o,
  output logic             backup_regulator_enable_o,
  output logic             wake_pin_function_enable_o,
  output logic             standby_enter_o,
  output logic             stop_enter_o,
  output logic             flash_powerdown_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] async_in;
  logic [3:0] sync_in;
  logic       wake_pin_s;
  logic       below_s;
  logic       bk_rdy_s;
  logic       sc_rdy_s;

  assign async_in = {scaling_ready_i, backup_regulator_ready_i, detector_below_i, wake_pin_i};

  // One chain per external level
  genvar gi;
  generate
    for (gi = 0; gi < pmcsr_pkg::NUM_SYNC; gi++) begin : g_sync
      pmcsr_sync u_sync (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .async_i (async_in[gi]),
        .sync_o  (sync_in[gi])
      );
    end
  endgenerate

  assign wake_pin_s = sync_in[0];
  assign below_s    = sync_in[1];
  assign bk_rdy_s   = sync_in[2];
  assign sc_rdy_s   = sync_in[3];

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  pmcsr_pkg::pmcsr_bus_st_t st_ff, nxt_st;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready;
  logic        pslverr_ff, nxt_pslverr;
  logic        setup;
  logic        hit_ctrl;
  logic        hit_csts;
  logic        wr_done;
  logic [31:0] ctrl_rd;
  logic [31:0] csts_rd;

  pmcsr_pkg::pmcsr_ctrl_t ctrl_ff, nxt_ctrl;
  pmcsr_pkg::pmcsr_csts_t csts_ff, nxt_csts;

  assign setup    = psel_i && !penable_i;
  assign hit_ctrl = (paddr_i == pmcsr_pkg::OFS_CTRL);
  assign hit_csts = (paddr_i == pmcsr_pkg::OFS_CSTS);
  assign wr_done  = psel_i && penable_i && pwrite_i && pready_ff;

  // Read images, strobes and reserved bits read zero
  always_comb begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[pmcsr_pkg::CTRL_LPSEL_POS]  = ctrl_ff.stop_regulator_lowpower_sel;
    ctrl_rd[pmcsr_pkg::CTRL_SBSEL_POS]  = ctrl_ff.deepsleep_standby_sel;
    ctrl_rd[pmcsr_pkg::CTRL_DETEN_POS]  = ctrl_ff.supply_detector_enable;
    ctrl_rd[pmcsr_pkg::CTRL_THR_MSB:pmcsr_pkg::CTRL_THR_LSB] = ctrl_ff.detector_threshold_select;
    ctrl_rd[pmcsr_pkg::CTRL_BKWEN_POS]  = ctrl_ff.backup_domain_write_enable;
    ctrl_rd[pmcsr_pkg::CTRL_FLPD_POS]   = ctrl_ff.flash_powerdown_in_stop;
    ctrl_rd[pmcsr_pkg::CTRL_SCALE_POS]  = ctrl_ff.scaling_sel;
    csts_rd = 32'h0000_0000;
    csts_rd[pmcsr_pkg::CSTS_WAKE_POS]   = csts_ff.wake_event_flag;
    csts_rd[pmcsr_pkg::CSTS_SBY_POS]    = csts_ff.standby_entered_flag;
    csts_rd[pmcsr_pkg::CSTS_BELOW_POS]  = csts_ff.supply_below_threshold_flag;
    csts_rd[pmcsr_pkg::CSTS_BKRDY_POS]  = csts_ff.backup_regulator_ready_flag;
    csts_rd[pmcsr_pkg::CSTS_WPEN_POS]   = csts_ff.wake_pin_function_enable;
    csts_rd[pmcsr_pkg::CSTS_BKEN_POS]   = csts_ff.backup_regulator_enable;
    csts_rd[pmcsr_pkg::CSTS_SCRDY_POS]  = csts_ff.scaling_ready_flag;
  end

  // Bus sequencing, status reads get one wait cycle
  always_comb begin
    nxt_st      = st_ff;
    nxt_prdata  = prdata_ff;
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    case (st_ff)
      pmcsr_pkg::PMCSR_IDLE: begin
        if (setup) begin
          nxt_prdata  = 32'h0000_0000;
          nxt_pslverr = !(hit_ctrl || hit_csts);
          if (!pwrite_i && hit_csts) begin
            nxt_st = pmcsr_pkg::PMCSR_WAIT;
          end else begin
            nxt_st     = pmcsr_pkg::PMCSR_ACC;
            nxt_pready = 1'b1;
            if (!pwrite_i && hit_ctrl) begin
              nxt_prdata = ctrl_rd;
            end
          end
        end
      end
      pmcsr_pkg::PMCSR_WAIT: begin
        nxt_st     = pmcsr_pkg::PMCSR_ACC;
        nxt_pready = 1'b1;
        nxt_prdata = csts_rd;
      end
      pmcsr_pkg::PMCSR_ACC: begin
        nxt_st     = pmcsr_pkg::PMCSR_IDLE;
        nxt_prdata = 32'h0000_0000;
      end
      default: begin
        nxt_st = pmcsr_pkg::PMCSR_IDLE;
      end
    endcase
    if (!rst_b_i) begin
      nxt_st      = pmcsr_pkg::PMCSR_IDLE;
      nxt_prdata  = 32'h0000_0000;
      nxt_pready  = 1'b0;
      nxt_pslverr = 1'b0;
    end
  end

  // Bus slave registers
  always_ff @(posedge mclk_i) begin
    st_ff      <= nxt_st;
    prdata_ff  <= nxt_prdata;
    pready_ff  <= nxt_pready;
    pslverr_ff <= nxt_pslverr;
  end

  // ----------------------------------------------------------------
  // Control register and clear strobes
  // ----------------------------------------------------------------
  logic                             wr_ctrl;
  logic                             wr_csts;
  logic [pmcsr_pkg::WCLR_DLY_CYC-1:0] wclr_ff, nxt_wclr;
  logic                             sclr;

  assign wr_ctrl = wr_done && hit_ctrl;
  assign wr_csts = wr_done && hit_csts;
  assign sclr    = wr_ctrl && pwdata_i[pmcsr_pkg::CTRL_SCLR_POS];

  // Next control value, reset on power-on or standby wake
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl.stop_regulator_lowpower_sel = pwdata_i[pmcsr_pkg::CTRL_LPSEL_POS];
      nxt_ctrl.deepsleep_standby_sel       = pwdata_i[pmcsr_pkg::CTRL_SBSEL_POS];
      nxt_ctrl.supply_detector_enable      = pwdata_i[pmcsr_pkg::CTRL_DETEN_POS];
      nxt_ctrl.detector_threshold_select   =
        pwdata_i[pmcsr_pkg::CTRL_THR_MSB:pmcsr_pkg::CTRL_THR_LSB];
      nxt_ctrl.backup_domain_write_enable  = pwdata_i[pmcsr_pkg::CTRL_BKWEN_POS];
      nxt_ctrl.flash_powerdown_in_stop     = pwdata_i[pmcsr_pkg::CTRL_FLPD_POS];
      nxt_ctrl.scaling_sel                 = pwdata_i[pmcsr_pkg::CTRL_SCALE_POS];
    end
    // Wake-flag clear travels a two-stage delay line
    nxt_wclr = {wclr_ff[pmcsr_pkg::WCLR_DLY_CYC-2:0],
                wr_ctrl && pwdata_i[pmcsr_pkg::CTRL_WCLR_POS]};
    if (!rst_b_i || !sys_rst_b_i) begin
      // Each field taken from its own position of the reset image
      nxt_ctrl.stop_regulator_lowpower_sel = pmcsr_pkg::CTRL_RST_VAL[pmcsr_pkg::CTRL_LPSEL_POS];
      nxt_ctrl.deepsleep_standby_sel       = pmcsr_pkg::CTRL_RST_VAL[pmcsr_pkg::CTRL_SBSEL_POS];
      nxt_ctrl.supply_detector_enable      = pmcsr_pkg::CTRL_RST_VAL[pmcsr_pkg::CTRL_DETEN_POS];
      nxt_ctrl.detector_threshold_select   =
        pmcsr_pkg::CTRL_RST_VAL[pmcsr_pkg::CTRL_THR_MSB:pmcsr_pkg::CTRL_THR_LSB];
      nxt_ctrl.backup_domain_write_enable  = pmcsr_pkg::CTRL_RST_VAL[pmcsr_pkg::CTRL_BKWEN_POS];
      nxt_ctrl.flash_powerdown_in_stop     = pmcsr_pkg::CTRL_RST_VAL[pmcsr_pkg::CTRL_FLPD_POS];
      nxt_ctrl.scaling_sel                 = pmcsr_pkg::CTRL_RST_VAL[pmcsr_pkg::CTRL_SCALE_POS];
      nxt_wclr = '0;
    end
  end

  // Control registers
  always_ff @(posedge mclk_i) begin
    ctrl_ff <= nxt_ctrl;
    wclr_ff <= nxt_wclr;
  end

  // ----------------------------------------------------------------
  // Status register and mode entry
  // ----------------------------------------------------------------
  logic wake_evt;
  logic sby_go;
  logic stop_go;
  logic in_standby_ff, nxt_in_standby;
  logic sby_pls_ff, nxt_sby_pls;
  logic stop_pls_ff, nxt_stop_pls;
  logic flpd_ff, nxt_flpd;

  // Wake sources: enabled pin at high level or any calendar event
  assign wake_evt = (csts_ff.wake_pin_function_enable && wake_pin_s) ||
                    rtc_alarm_i || rtc_tamper_i || rtc_timestamp_i || rtc_wakeup_i;
  // Deep sleep entry decision on a wait instruction
  assign sby_go  = wait_instr_i && deepsleep_i && ctrl_ff.deepsleep_standby_sel &&
                   !csts_ff.wake_event_flag;
  assign stop_go = wait_instr_i && deepsleep_i && !ctrl_ff.deepsleep_standby_sel;

  // Next status; hardware set wins over clear
  always_comb begin
    nxt_csts = csts_ff;
    nxt_in_standby = in_standby_ff;
    if (sby_go) begin
      nxt_in_standby = 1'b1;
    end else if (wake_evt) begin
      nxt_in_standby = 1'b0;
    end
    if (wclr_ff[pmcsr_pkg::WCLR_DLY_CYC-1]) begin
      nxt_csts.wake_event_flag = 1'b0;
    end
    if (wake_evt) begin
      nxt_csts.wake_event_flag = 1'b1;
    end
    if (sclr) begin
      nxt_csts.standby_entered_flag = 1'b0;
    end
    if (sby_go) begin
      nxt_csts.standby_entered_flag = 1'b1;
    end
    nxt_csts.supply_below_threshold_flag = below_s && ctrl_ff.supply_detector_enable &&
                                           !in_standby_ff;
    nxt_csts.backup_regulator_ready_flag = bk_rdy_s && csts_ff.backup_regulator_enable;
    nxt_csts.scaling_ready_flag          = sc_rdy_s;
    if (wr_csts) begin
      nxt_csts.wake_pin_function_enable = pwdata_i[pmcsr_pkg::CSTS_WPEN_POS];
      nxt_csts.backup_regulator_enable  = pwdata_i[pmcsr_pkg::CSTS_BKEN_POS];
    end
    if (!sys_rst_b_i) begin
      nxt_csts.wake_pin_function_enable = 1'b0;
    end
    nxt_sby_pls  = sby_go;
    nxt_stop_pls = stop_go;
    nxt_flpd     = stop_go ? ctrl_ff.flash_powerdown_in_stop :
                   (wake_evt ? 1'b0 : flpd_ff);
    if (!rst_b_i) begin
      nxt_csts       = pmcsr_pkg::pmcsr_csts_t'(7'h00);
      nxt_in_standby = 1'b0;
      nxt_sby_pls    = 1'b0;
      nxt_stop_pls   = 1'b0;
      nxt_flpd       = 1'b0;
    end else if (!sys_rst_b_i) begin
      nxt_in_standby = 1'b0;
      nxt_sby_pls    = 1'b0;
      nxt_stop_pls   = 1'b0;
      nxt_flpd       = 1'b0;
    end
  end

  // Status registers
  always_ff @(posedge mclk_i) begin
    csts_ff       <= nxt_csts;
    in_standby_ff <= nxt_in_standby;
    sby_pls_ff    <= nxt_sby_pls;
    stop_pls_ff   <= nxt_stop_pls;
    flpd_ff       <= nxt_flpd;
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  assign prdata_o                   = prdata_ff;
  assign pready_o                   = pready_ff;
  assign pslverr_o                  = pslverr_ff;
  assign ctrl_o                     = ctrl_ff;
  assign backup_regulator_enable_o  = csts_ff.backup_regulator_enable;
  assign wake_pin_function_enable_o = csts_ff.wake_pin_function_enable;
  assign standby_enter_o            = sby_pls_ff;
  assign stop_enter_o               = stop_pls_ff;
  assign flash_powerdown_o          = flpd_ff;

endmodule
`default_nettype wire

// ---- pmcsr_regs_chk.sv ----
// Assertion checker for the power control and status register bank
`timescale 1ns/1ns
`default_nettype none
module pmcsr_regs_chk (
  input wire logic                   mclk_i,
  input wire logic                   rst_b_i,
  input wire logic                   sys_rst_b_i,
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic                   pwrite_i,
  input wire logic [11:0]            paddr_i,
  input wire logic [31:0]            prdata_o,
  input wire logic                   pready_o,
  input wire logic                   pslverr_o,
  input wire logic                   deepsleep_i,
  input wire logic                   wait_instr_i,
  input wire pmcsr_pkg::pmcsr_ctrl_t ctrl_o,
  input wire logic                   wake_pin_function_enable_o,
  input wire logic                   standby_enter_o,
  input wire logic                   stop_enter_o,
  input wire logic                   flash_powerdown_o
);
  // ----------------------------------------------------------------
  // Helper terms
  // ----------------------------------------------------------------
  logic setup_w, ctrl_wr_w, sby_req_w, stop_req_w, fpd_w;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // Setup phase, control update causes and sleep requests
  assign setup_w    = psel_i && !penable_i;
  assign ctrl_wr_w  = !sys_rst_b_i || (psel_i && penable_i && pwrite_i && pready_o && paddr_i == 12'h000);
  assign sby_req_w  = wait_instr_i && deepsleep_i && ctrl_o.deepsleep_standby_sel;
  assign stop_req_w = wait_instr_i && deepsleep_i && !ctrl_o.deepsleep_standby_sel;
  assign fpd_w      = ctrl_o.flash_powerdown_in_stop;

  csts_wait_a: assert property (setup_w && !pwrite_i && paddr_i == 12'h004 |=> !pready_o ##1 pready_o)
    else $error("status read without one wait state");
  ctrl_fast_a: assert property (setup_w && paddr_i == 12'h000 |=> pready_o)
    else $error("control access not answered next cycle");
  rdy_once_a: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data not zero outside answer");
  unmap_err_a: assert property (setup_w && paddr_i != 12'h000 && paddr_i != 12'h004 |=> pready_o && pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  ctrl_sysrst_a: assert property (!sys_rst_b_i |=> ctrl_o == 9'h100)
    else $error("control not reset by system reset");
  wpen_sysrst_a: assert property (!sys_rst_b_i |=> !wake_pin_function_enable_o)
    else $error("wake pin enable kept over system reset");
  ctrl_hold_a: assert property (!$stable(ctrl_o) |-> $past(ctrl_wr_w))
    else $error("control changed without write");
  sby_cond_a: assert property (standby_enter_o |-> $past(sby_req_w))
    else $error("standby entered without request");
  stop_cond_a: assert property (stop_enter_o |-> $past(stop_req_w))
    else $error("stop entered without request");
  flash_pd_a: assert property (stop_enter_o && $past(fpd_w) |-> ##[0:1] flash_powerdown_o)
    else $error("flash not powered down on stop");

  // Main scenarios reached
  cover property (standby_enter_o);
  cover property (stop_enter_o);
  cover property (pslverr_o);
endmodule

bind pmcsr_regs pmcsr_regs_chk u_pmcsr_regs_chk (.mclk_i, .rst_b_i, .sys_rst_b_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .prdata_o, .pready_o, .pslverr_o, .deepsleep_i, .wait_instr_i, .ctrl_o, .wake_pin_function_enable_o,
  .standby_enter_o, .stop_enter_o, .flash_powerdown_o);
`default_nettype wire

// ---- pmcsr_regs_tb_top.sv ----
// Self-checking testbench for the power control and status register bank
`timescale 1ns/1ns
`default_nettype none
module pmcsr_regs_tb_top;
  // ----------------------------------------------------------------
  // Signals and design instance
  // ----------------------------------------------------------------
  logic                   mclk_i, rst_b_i, sys_rst_b_i, psel_i, penable_i, pwrite_i, wake_pin_i;
  logic                   detector_below_i, backup_regulator_ready_i, scaling_ready_i, deepsleep_i, wait_instr_i;
  logic [3:0]             rtc_ev;
  logic [11:0]            paddr_i;
  logic [31:0]            pwdata_i, prdata_o, rdata;
  logic                   pready_o, pslverr_o, bk_en, wp_en, sby, stp, fpd, err, s, p;
  pmcsr_pkg::pmcsr_ctrl_t ctrl_o;
  int                     num_errors, tests_run, waits;

  pmcsr_regs u_pmcsr_regs (.mclk_i, .rst_b_i, .sys_rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .wake_pin_i, .rtc_alarm_i(rtc_ev[0]), .rtc_tamper_i(rtc_ev[1]),
    .rtc_timestamp_i(rtc_ev[2]), .rtc_wakeup_i(rtc_ev[3]), .detector_below_i, .backup_regulator_ready_i,
    .scaling_ready_i, .deepsleep_i, .wait_instr_i, .ctrl_o, .backup_regulator_enable_o(bk_en),
    .wake_pin_function_enable_o(wp_en), .standby_enter_o(sby), .stop_enter_o(stp), .flash_powerdown_o(fpd));

  // Clock at 8 ns
  always #4 mclk_i = ~mclk_i;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One bus transfer, request held until ready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(negedge mclk_i);
    psel_i = 1'b1;
    pwrite_i = wr;
    paddr_i = a;
    pwdata_i = d;
    @(negedge mclk_i);
    penable_i = 1'b1;
    waits = 0;
    while (pready_o !== 1'b1 && waits < 8) begin
      @(negedge mclk_i);
      waits++;
    end
    if (waits == 8) begin
      num_errors++;
      $display("[FAIL] %0t no ready", $time);
      tally_and_finish();
    end
    rdata = prdata_o;
    err = pslverr_o;
    @(negedge mclk_i);
    psel_i = 1'b0;
    penable_i = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] w);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp, "read data");
    chk(32'(waits), w, "wait states");
    chk({31'h0, err}, 32'h0, "error flag");
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  task automatic ev(input int k);
    @(negedge mclk_i);
    rtc_ev = 4'h1 << k;
    @(negedge mclk_i);
    rtc_ev = 4'h0;
  endtask

  // Wait instruction pulse, collecting standby and stop pulses
  task automatic sleep_try();
    s = 1'b0;
    p = 1'b0;
    @(negedge mclk_i);
    wait_instr_i = 1'b1;
    @(negedge mclk_i);
    wait_instr_i = 1'b0;
    repeat (3) begin
      s |= sby;
      p |= stp;
      @(negedge mclk_i);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(12'h000, 32'h0000_4000, 0);
    rd(12'h004, 32'h0000_0000, 1);
    chk({23'h0, ctrl_o}, 32'h0000_0100, "ctrl out");
    $display("reset values done");
  endtask

  task automatic t_ctrl();
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    rd(12'h000, 32'h0000_43F3, 0);
    chk({23'h0, ctrl_o}, 32'h0000_01FF, "ctrl all set");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 12'h000, 32'(i) << 5);
      rd(12'h000, 32'(i) << 5, 0);
      chk({23'h0, ctrl_o}, 32'(i) << 3, "threshold code");
    end
    apb(1'b1, 12'h008, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h1, "unmapped write");
    apb(1'b0, 12'h008, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped read");
    chk(rdata, 32'h0, "unmapped data");
    rd(12'h000, 32'h0000_00E0, 0);
    $display("control register done");
  endtask

  task automatic t_status();
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    rd(12'h004, 32'h0000_0300, 1);
    chk({30'h0, bk_en, wp_en}, 32'h3, "status enables");
    apb(1'b1, 12'h000, 32'h0000_4010);
    detector_below_i = 1'b1;
    backup_regulator_ready_i = 1'b1;
    scaling_ready_i = 1'b1;
    cyc(4);
    rd(12'h004, 32'h0000_430C, 1);
    apb(1'b1, 12'h000, 32'h0000_4000);
    cyc(4);
    rd(12'h004, 32'h0000_4308, 1);
    apb(1'b1, 12'h004, 32'h0000_0100);
    rd(12'h004, 32'h0000_4100, 1);
    $display("status register done");
  endtask

  task automatic t_wake();
    wake_pin_i = 1'b1;
    cyc(4);
    wake_pin_i = 1'b0;
    cyc(3);
    rd(12'h004, 32'h0000_4101, 1);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 12'h000, 32'h0000_4004);
      cyc(3);
      rd(12'h004, 32'h0000_4100, 1);
      ev(k);
      cyc(2);
      rd(12'h004, 32'h0000_4101, 1);
    end
    apb(1'b1, 12'h000, 32'h0000_4004);
    cyc(3);
    $display("wake events done");
  endtask

  task automatic t_sleep();
    deepsleep_i = 1'b1;
    apb(1'b1, 12'h000, 32'h0000_4002);
    sleep_try();
    chk({30'h0, s, p}, 32'h2, "standby entry");
    rd(12'h004, 32'h0000_4102, 1);
    ev(0);
    sleep_try();
    chk({30'h0, s, p}, 32'h0, "blocked by wake flag");
    @(negedge mclk_i);
    sys_rst_b_i = 1'b0;
    @(negedge mclk_i);
    sys_rst_b_i = 1'b1;
    rd(12'h000, 32'h0000_4000, 0);
    rd(12'h004, 32'h0000_4003, 1);
    apb(1'b1, 12'h000, 32'h0000_4008);
    apb(1'b1, 12'h000, 32'h0000_4004);
    cyc(3);
    rd(12'h004, 32'h0000_4000, 1);
    apb(1'b1, 12'h000, 32'h0000_4200);
    sleep_try();
    chk({29'h0, s, p, fpd}, 32'h3, "stop with flash down");
    ev(2);
    cyc(2);
    chk({31'h0, fpd}, 32'h0, "flash up on wake");
    $display("sleep entry done");
  endtask

  // Main sequence
  initial begin
    {mclk_i, rst_b_i, sys_rst_b_i, psel_i, penable_i, pwrite_i, wake_pin_i, deepsleep_i, wait_instr_i} = 9'h000;
    {detector_below_i, backup_regulator_ready_i, scaling_ready_i} = 3'h0;
    rtc_ev = 4'h0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    num_errors = 0;
    tests_run = 0;
    repeat (16) @(negedge mclk_i);
    rst_b_i = 1'b1;
    sys_rst_b_i = 1'b1;
    t_reset();
    t_ctrl();
    t_status();
    t_wake();
    t_sleep();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ---- pmcsr_sync.sv ----
// Two-flop synchroniser for a single level input
`timescale 1ns/1ns
`default_nettype none
module pmcsr_sync (
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  input  wire logic async_i,
  output logic      sync_o
);

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  // Next values, first stage feeds only the second
  always_comb begin
    nxt_meta = async_i;
    nxt_sync = meta_ff;
    if (!rst_b_i) begin
      nxt_meta = 1'b0;
      nxt_sync = 1'b0;
    end
  end

  // Register stages
  always_ff @(posedge mclk_i) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  assign sync_o = sync_ff;

endmodule
`default_nettype wire
